// file: rtl/adcsc_consts.svh
// Purpose: constants for the converter sequencing control block
// Assumes: included by the top module; the package does not include it
// Notes: offsets are word-aligned byte addresses
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH
`define ADCSC_OFF_CTRL1 8'h00
`define ADCSC_OFF_CTRL2 8'h04
`define ADCSC_OFF_CHSEL 8'h08
`define ADCSC_OFF_SCAN 8'h0C
`define ADCSC_OFF_BUF0 8'h40
`define ADCSC_BUF_WORDS 22
`define ADCSC_HALF_WORDS 11
`define ADCSC_BIT_ON 15
`define ADCSC_SSRC_LSB 4
`define ADCSC_BIT_RES 3
`define ADCSC_BIT_AUTO_SAMPLE_START 2
`define ADCSC_BIT_SAMPLE_CONTROL 1
`define ADCSC_BIT_DONE 0
`define ADCSC_VCFG_LSB 13
`define ADCSC_BIT_OFFSET_CALIBRATE 12
`define ADCSC_BIT_BUFREG 11
`define ADCSC_BIT_SCAN 10
`define ADCSC_BIT_FILLH 7
`define ADCSC_SMPI_LSB 2
`define ADCSC_BIT_SPLIT 1
`define ADCSC_TRG_MANUAL 4'h0
`define ADCSC_TRG_EXTIRQ 4'h1
`define ADCSC_TRG_TMR3 4'h2
`define ADCSC_TRG_TMR1 4'h6
`define ADCSC_CONV_NS 1200
`define ADCSC_CLK_NS 100
`define ADCSC_CONV_CYC ((`ADCSC_CONV_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)
`define ADCSC_CTRL1_MASK 32'h000080FE
`define ADCSC_CTRL2_MASK 32'h0000FCBE
`endif

// file: rtl/adcsc_pkg.sv
// Purpose: types for the converter sequencing control block
// Assumes: constants come from adcsc_consts.svh
// Notes: none
package adcsc_pkg;
  typedef enum logic [1:0] {
    ADCSC_IDLE,
    ADCSC_SAMPLE,
    ADCSC_CONVERT
  } adcsc_state_t;
  typedef struct packed {
    adcsc_state_t st;
    logic [31:0] ctrl1;
    logic [31:0] ctrl2;
    logic [3:0] chsel;
    logic [15:0] scan;
    logic [3:0] scan_idx;
    logic [3:0] seq_cnt;
    logic [4:0] wr_ptr;
    logic [3:0] conv_cnt;
    logic [31:0] rdata;
    logic start_conv;
    logic irq;
    logic [3:0] pos_sel;
    logic neg_sel;
    logic cal;
    logic res12;
    logic [2:0] vref;
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic ext_d;
  } adcsc_st_t;
endpackage : adcsc_pkg

// file: rtl/adcsc_top.sv
// Purpose: sample/convert sequencing, trigger choice and result buffering
// Assumes: converter core reports result with result_valid_i pulse
// Notes: timer triggers are same-clock pulses; ext irq pin is synchronised
// Summary of operation
// - manual code: clearing sample bit starts conversion
// - code 0001: ext irq edge starts conversion
// - code 0110: timer1 match, not in sleep
// - code 0010: timer3 match; reserved codes ignored
// - resolution bit selects 12 or 10 bits
// - auto start resamples after conversion ends
// - writing one to sample bit starts sampling
// - manual mode: writing zero starts conversion
// - module off forces sample bit zero
// - done set on completion; clear harmless
// - auto modes clear done at next sample
// - reference field selects reference pair
// - offset calibrate ties inputs to negative reference
// - per-channel buffer slots, else fifo
// - split mode gives two 11-word halves
// - fill-half bit shows half being filled
// - sequences field sets interrupt spacing
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "adcsc_consts.svh"
module adcsc_top
  import adcsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ext_irq_zero_i,
  input wire logic tmr1_match_i,
  input wire logic tmr3_match_i,
  input wire logic sleep_i,
  input wire logic result_valid_i,
  input wire logic [11:0] result_i,
  output logic sampling_o,
  output logic start_conv_o,
  output logic res12_o,
  output logic [2:0] reference_sel_o,
  output logic offset_calibrate_o,
  output logic [3:0] pos_input_o,
  output logic neg_input_o,
  output logic adc_irq_o
);
  adcsc_st_t s_r;
  adcsc_st_t s_nxt;
  logic [11:0] result_buffer [0:`ADCSC_BUF_WORDS-1];
  logic [4:0] buf_wa;
  logic buf_we;

  function automatic logic [3:0] next_scan(input logic [15:0] sel, input logic [3:0] cur);
    logic [3:0] i;
    logic found;
    next_scan = cur;
    found = 1'b0;
    for (int k = 1; k <= 16; k++) begin
      i = cur + k[3:0];
      if (!found && sel[i]) begin
        next_scan = i;
        found = 1'b1;
      end
    end
  endfunction : next_scan

  always_comb begin
    logic on;
    logic trig;
    logic ext_edge;
    logic sample_control_wr;
    logic [3:0] src;
    logic [4:0] slot;
    logic [4:0] half_base;
    trig = 1'b0;
    slot = 5'h00;
    half_base = 5'h00;
    s_nxt = s_r;
    s_nxt.start_conv = 1'b0;
    s_nxt.irq = 1'b0;
    buf_we = 1'b0;
    buf_wa = 5'h00;
    on = s_r.ctrl1[`ADCSC_BIT_ON];
    src = s_r.ctrl1[`ADCSC_SSRC_LSB +: 4];
    sample_control_wr = 1'b0;
    s_nxt.ext_s1 = {1'b0, ext_irq_zero_i};
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_d = s_r.ext_s2[0];
    ext_edge = s_r.ext_s2[0] & ~s_r.ext_d;
    unique case (src)
      `ADCSC_TRG_EXTIRQ: trig = ext_edge;
      `ADCSC_TRG_TMR3: trig = tmr3_match_i;
      `ADCSC_TRG_TMR1: trig = tmr1_match_i & ~sleep_i;
      default: trig = 1'b0;
    endcase
    if (wr_i) begin
      unique case (addr_i)
        `ADCSC_OFF_CTRL1: begin
          s_nxt.ctrl1 = (wdata_i & `ADCSC_CTRL1_MASK) | {31'h0, s_r.ctrl1[`ADCSC_BIT_DONE] & wdata_i[0]};
          s_nxt.ctrl1[`ADCSC_BIT_SAMPLE_CONTROL] = s_r.ctrl1[`ADCSC_BIT_SAMPLE_CONTROL];
          sample_control_wr = 1'b1;
        end
        `ADCSC_OFF_CTRL2: begin
          s_nxt.ctrl2 = (wdata_i & `ADCSC_CTRL2_MASK) | {24'h0, s_r.ctrl2[`ADCSC_BIT_FILLH], 7'h00};
          s_nxt.ctrl2[`ADCSC_BIT_FILLH] = s_r.ctrl2[`ADCSC_BIT_FILLH];
        end
        `ADCSC_OFF_CHSEL: s_nxt.chsel = wdata_i[3:0];
        `ADCSC_OFF_SCAN: s_nxt.scan = wdata_i[15:0];
        default: ;
      endcase
    end
    unique case (s_r.st)
      ADCSC_IDLE: begin
        if (sample_control_wr && wdata_i[`ADCSC_BIT_SAMPLE_CONTROL] && wdata_i[`ADCSC_BIT_ON]) begin
          s_nxt.st = ADCSC_SAMPLE;
        end
      end
      ADCSC_SAMPLE: begin
        if ((src == `ADCSC_TRG_MANUAL && sample_control_wr && !wdata_i[`ADCSC_BIT_SAMPLE_CONTROL]) || trig) begin
          s_nxt.st = ADCSC_CONVERT;
          s_nxt.start_conv = 1'b1;
          s_nxt.conv_cnt = 4'(`ADCSC_CONV_CYC);
        end
      end
      ADCSC_CONVERT: begin
        if (s_r.conv_cnt != 4'h0) begin
          s_nxt.conv_cnt = s_r.conv_cnt - 4'h1;
        end
        if (result_valid_i) begin
          s_nxt.ctrl1[`ADCSC_BIT_DONE] = 1'b1;
          half_base = (s_r.ctrl2[`ADCSC_BIT_SPLIT] && s_r.ctrl2[`ADCSC_BIT_FILLH]) ? 5'(`ADCSC_HALF_WORDS) : 5'h00;
          slot = s_r.ctrl2[`ADCSC_BIT_BUFREG] ? {1'b0, s_r.pos_sel} : half_base + s_r.wr_ptr;
          buf_we = 1'b1;
          buf_wa = slot;
          s_nxt.wr_ptr = s_r.wr_ptr + 5'h01;
          if (s_r.ctrl2[`ADCSC_BIT_SCAN]) begin
            s_nxt.scan_idx = next_scan(s_r.scan, s_r.scan_idx);
          end
          if (s_r.seq_cnt == s_r.ctrl2[`ADCSC_SMPI_LSB +: 4]) begin
            s_nxt.seq_cnt = 4'h0;
            s_nxt.irq = 1'b1;
            s_nxt.wr_ptr = 5'h00;
            if (s_r.ctrl2[`ADCSC_BIT_SPLIT]) begin
              s_nxt.ctrl2[`ADCSC_BIT_FILLH] = ~s_r.ctrl2[`ADCSC_BIT_FILLH];
            end
          end else begin
            s_nxt.seq_cnt = s_r.seq_cnt + 4'h1;
          end
          if (s_nxt.wr_ptr >= 5'((s_r.ctrl2[`ADCSC_BIT_SPLIT]) ? `ADCSC_HALF_WORDS : `ADCSC_BUF_WORDS)) begin
            s_nxt.wr_ptr = 5'h00;
          end
          if (s_r.ctrl1[`ADCSC_BIT_AUTO_SAMPLE_START]) begin
            s_nxt.st = ADCSC_SAMPLE;
          end else begin
            s_nxt.st = ADCSC_IDLE;
          end
        end
      end
      default: s_nxt.st = ADCSC_IDLE;
    endcase
    if (s_r.st != ADCSC_SAMPLE && s_nxt.st == ADCSC_SAMPLE && s_r.ctrl1[`ADCSC_BIT_AUTO_SAMPLE_START]
        && !result_valid_i) begin
      s_nxt.ctrl1[`ADCSC_BIT_DONE] = 1'b0;
    end
    if (s_r.st == ADCSC_SAMPLE && s_nxt.st == ADCSC_SAMPLE && s_r.ctrl1[`ADCSC_BIT_AUTO_SAMPLE_START]
        && s_r.ctrl1[`ADCSC_BIT_DONE] && !sample_control_wr) begin
      s_nxt.ctrl1[`ADCSC_BIT_DONE] = 1'b0;
    end
    if (s_r.st == ADCSC_IDLE && s_r.ctrl1[`ADCSC_BIT_AUTO_SAMPLE_START] && on) begin
      s_nxt.st = ADCSC_SAMPLE;
    end
    if (!s_nxt.ctrl1[`ADCSC_BIT_ON]) begin
      s_nxt.st = ADCSC_IDLE;
    end
    s_nxt.ctrl1[`ADCSC_BIT_SAMPLE_CONTROL] = (s_nxt.st == ADCSC_SAMPLE);
    s_nxt.rdata = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        `ADCSC_OFF_CTRL1: s_nxt.rdata = s_r.ctrl1;
        `ADCSC_OFF_CTRL2: s_nxt.rdata = s_r.ctrl2;
        `ADCSC_OFF_CHSEL: s_nxt.rdata = {28'h0, s_r.chsel};
        `ADCSC_OFF_SCAN: s_nxt.rdata = {16'h0, s_r.scan};
        default: begin
          if (addr_i >= `ADCSC_OFF_BUF0 && addr_i < 8'(`ADCSC_OFF_BUF0 + 4 * `ADCSC_BUF_WORDS)
              && addr_i[1:0] == 2'h0) begin
            s_nxt.rdata = {20'h0, result_buffer[5'(addr_i[7:2] - 6'h10)]};
          end
        end
      endcase
    end
    s_nxt.cal = s_r.ctrl2[`ADCSC_BIT_OFFSET_CALIBRATE];
    s_nxt.pos_sel = s_r.ctrl2[`ADCSC_BIT_SCAN] ? s_r.scan_idx : s_r.chsel;
    s_nxt.neg_sel = s_r.ctrl2[`ADCSC_BIT_OFFSET_CALIBRATE];
    s_nxt.res12 = s_r.ctrl1[`ADCSC_BIT_RES];
    s_nxt.vref = s_r.ctrl2[`ADCSC_VCFG_LSB +: 3];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // buffer holds data only, so it needs no reset
  always_ff @(posedge clk_i) begin
    if (buf_we) begin
      result_buffer[buf_wa] <= result_i;
    end
  end

  assign rdata_o = s_r.rdata;
  assign sampling_o = s_r.ctrl1[`ADCSC_BIT_SAMPLE_CONTROL];
  assign start_conv_o = s_r.start_conv;
  assign res12_o = s_r.res12;
  assign reference_sel_o = s_r.vref;
  assign offset_calibrate_o = s_r.cal;
  assign pos_input_o = s_r.pos_sel;
  assign neg_input_o = s_r.neg_sel;
  assign adc_irq_o = s_r.irq;
endmodule : adcsc_top

// file: sim/adcsc_core_model.sv
// Purpose: stand-in for the sample-and-hold and converter core
// Assumes: one start pulse per conversion
// Notes: data toggles outside the valid pulse, so after a result it matches 12'hA5C again every other cycle
`timescale 1ns/1ps
module adcsc_core_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [3:0] extra_i,
  output logic valid_o = 1'h0,
  output logic [11:0] data_o = 12'h000
);
  int cnt = 0;
  always @(posedge clk_i) begin
    if (start_i) cnt <= 12 + extra_i;
    else if (cnt > 0) cnt <= cnt - 1;
    valid_o <= cnt == 1 && !start_i;
    data_o <= (cnt == 1) ? 12'hA5C : ~data_o;
  end
endmodule : adcsc_core_model

// file: sim/adcsc_top_chk.sv
// Purpose: port checks for the sequencing block
// Assumes: first control register at offset 0x00
// Notes: shadows control writes to know the trigger code
`timescale 1ns/1ps
module adcsc_top_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic tmr1_match_i,
  input wire logic tmr3_match_i,
  input wire logic sleep_i,
  input wire logic result_valid_i,
  input wire logic sampling_o,
  input wire logic start_conv_o,
  input wire logic res12_o,
  input wire logic adc_irq_o
);
  logic [15:0] c1_r;
  logic w1;
  assign w1 = wr_i && addr_i == 8'h00;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) c1_r <= 16'h0000;
    else if (w1) c1_r <= wdata_i[15:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_t3; c1_r[15] && c1_r[7:4] == 4'h2 && sampling_o && tmr3_match_i && !wr_i |=> start_conv_o; endproperty
  a_t3: assert property (p_t3) else $error("timer3 start missed");
  property p_slp; c1_r[7:4] == 4'h6 && sleep_i && tmr1_match_i && !wr_i |=> !start_conv_o; endproperty
  a_slp: assert property (p_slp) else $error("start during sleep");
  property p_man; w1 && wdata_i[15] && !wdata_i[1] && wdata_i[7:4] == 4'h0 && c1_r[7:4] == 4'h0
    && sampling_o |=> start_conv_o && !sampling_o; endproperty
  a_man: assert property (p_man) else $error("manual start missed");
  property p_off; w1 && !wdata_i[15] |=> !sampling_o; endproperty
  a_off: assert property (p_off) else $error("sampling while off");
  property p_smp; w1 && wdata_i[15] && wdata_i[1] && !start_conv_o |=> sampling_o; endproperty
  a_smp: assert property (p_smp) else $error("sampling not started");
  property p_res; w1 |=> ##1 res12_o == $past(wdata_i[3], 2); endproperty
  a_res: assert property (p_res) else $error("resolution output wrong");
  property p_irq; adc_irq_o |-> $past(result_valid_i); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without result");
  property p_auto; c1_r[15] && c1_r[2] && result_valid_i && !wr_i |-> ##[1:2] sampling_o; endproperty
  a_auto: assert property (p_auto) else $error("auto sample missed");
  c_conv: cover property (start_conv_o);
  c_irq: cover property (adc_irq_o);
  c_smp: cover property ($rose(sampling_o));
endmodule : adcsc_top_chk
bind adcsc_top adcsc_top_chk i_adcsc_top_chk (.*);

// file: sim/adcsc_top_tb.sv
// Purpose: self-checking bench for the sequencing block
// Assumes: core model answers 12 cycles after start plus extra
// Notes: register rows, trigger rows, then auto and split buffer
`timescale 1ns/1ps
module adcsc_top_tb;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, sleep_i = 1'h0;
  logic ext_irq_zero_i = 1'h0, tmr1_match_i = 1'h0, tmr3_match_i = 1'h0, result_valid_i;
  logic sampling_o, start_conv_o, res12_o, offset_calibrate_o, neg_input_o, adc_irq_o;
  logic [2:0] reference_sel_o;
  logic [3:0] pos_input_o, extra = 4'h0;
  logic [7:0] addr_i = 8'h00;
  logic [11:0] result_i;
  logic [31:0] wdata_i = 32'h0, rdata_o, q;
  int miscompares = 0, cmp_count = 0;
  // address, write value, read-back value
  logic [71:0] rows [5] = '{{8'h00, 32'hFFFF7FFF, 32'h000000FC}, {8'h04, 32'hFFFFFFFF, 32'h0000FC3E},
    {8'h04, 32'h0, 32'h0}, {8'h10, 32'hFFFFFFFF, 32'h0}, {8'h00, 32'h0, 32'h0}};
  // code, {sleep, ext, tmr1, tmr3}, start expected
  logic [8:0] trg [6] = '{{4'h2, 4'h1, 1'h1}, {4'h6, 4'hA, 1'h0}, {4'h6, 4'h2, 1'h1},
    {4'h3, 4'h7, 1'h0}, {4'h1, 4'h4, 1'h1}, {4'h0, 4'h7, 1'h0}};
  adcsc_top i_adcsc_top (.*);
  adcsc_core_model i_adcsc_core_model (.clk_i(clk_i), .start_i(start_conv_o), .extra_i(extra),
    .valid_o(result_valid_i), .data_o(result_i));
  task automatic chk(input logic [31:0] s, e, input string n);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 q = rdata_o;
  endtask : rd
  // poll just after each edge so one-cycle pulses are not missed
  task automatic wt(ref logic s, input int n);
    #1;
    while (s !== 1'h1) begin
      @(posedge clk_i);
      #1;
      if (--n == 0) begin
        miscompares++;
        $display("unexpected wait exp 1 seen 0");
        final_report;
      end
    end
  endtask : wt
  initial forever #50 clk_i = ~clk_i;
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    chk({sampling_o, start_conv_o, adc_irq_o, res12_o}, 0, "reset_outputs");
    foreach (rows[i]) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64]);
      chk(q, rows[i][31:0], "register");
    end
    wr(8'h00, 32'h00008008);
    wr(8'h00, 32'h0000800A);
    chk(sampling_o, 1, "sampling");
    wr(8'h00, 32'h00008008);
    wt(start_conv_o, 4);
    chk(sampling_o, 0, "holding");
    wt(adc_irq_o, 40);
    rd(8'h00);
    chk(q, 32'h00008009, "done");
    rd(8'h40);
    chk(q, 32'h00000A5C, "result");
    chk(res12_o, 1, "res12");
    foreach (trg[i]) begin
      wr(8'h00, {16'h0000, 8'h80, trg[i][8:5], 4'h2});
      {sleep_i, ext_irq_zero_i, tmr1_match_i, tmr3_match_i} <= trg[i][4:1];
      @(posedge clk_i);
      {ext_irq_zero_i, tmr1_match_i, tmr3_match_i} <= 3'h0;
      if (trg[i][0]) wt(start_conv_o, 6);
      else repeat (8) @(posedge clk_i) #1 chk(start_conv_o, 0, "no_start");
      if (trg[i][0]) wt(adc_irq_o, 40);
    end
    extra <= 4'hF;
    wr(8'h04, 32'h00000006);
    wr(8'h00, 32'h00008026);
    for (int k = 0; k < 2; k++) begin
      tmr3_match_i <= 1'h1;
      @(posedge clk_i);
      tmr3_match_i <= 1'h0;
      wt(result_valid_i, 40);
      if (k == 1) wt(adc_irq_o, 2);
      wt(sampling_o, 3);
      @(posedge clk_i);
      rd(8'h00);
      chk(q, 32'h00008026, "auto_done");
    end
    rd(8'h04);
    chk(q, 32'h00000086, "fill_half");
    rd(8'h44);
    chk(q, 32'h00000A5C, "second_slot");
    wr(8'h04, 32'h00007000);
    @(posedge clk_i);
    #1 chk({reference_sel_o, offset_calibrate_o, neg_input_o}, 5'h0F, "ref_cal");
    wr(8'h08, 32'h00000005);
    @(posedge clk_i);
    #1 chk(pos_input_o, 4'h5, "chsel");
    wr(8'h00, 32'h00000002);
    chk(sampling_o, 0, "sample_control_off");
    final_report;
  end
endmodule : adcsc_top_tb
